/* File: core/csb_pkg.sv */
package csb_pkg;
  // ==========================================================
  // Widths.
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int BYTE_W = 8;
  // ==========================================================
  // Register indices; the byte address is four times the index.
  localparam logic [31:0] IDX_CTRL = 32'h00238000;
  localparam logic [31:0] IDX_STAT = 32'h00238004;
  localparam logic [31:0] IDX_IST = 32'h00238006;
  localparam logic [31:0] IDX_IMSK = 32'h00238008;
  localparam logic [31:0] IDX_BAUD = 32'h0023800A;
  localparam logic [31:0] IDX_TXB = 32'h0023800C;
  localparam logic [31:0] IDX_RXB = 32'h0023800E;
  // ==========================================================
  // Reset values and field positions.
  localparam logic [15:0] BAUD_RST = 16'h0007;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [2:0] IMSK_RST = 3'h0;
  localparam int TRANSMIT_ENABLE_BIT = 0;
  localparam int RECEIVE_ENABLE_BIT = 1;
  localparam int ST_TEMP = 0;
  localparam int ST_TX_SHIFT_EMPTY = 1;
  localparam int ST_RX_COMPLETE = 2;
  localparam int ST_OVERRUN = 3;
  localparam int N_EV = 3;
  localparam int EV_TEMP = 0;
  localparam int EV_RX_COMPLETE = 1;
  localparam int EV_OVR = 2;
  // ==========================================================
  // Serial timing in card clock periods and bit counts.
  localparam logic [8:0] BIT_CARD_CLKS = 9'h17E;
  localparam logic [8:0] HALF_BIT = 9'h0BF;
  localparam logic [3:0] TX_BITS = 4'hC;
  localparam logic [3:0] RX_BITS = 4'hA;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_TX = 3'b010,
    ENG_RX = 3'b100
  } csb_eng_t;

  function automatic logic csb_hit(input logic [31:0] a,
                                   input logic [31:0] idx);
    return a == {idx[29:0], 2'b00};
  endfunction
endpackage

/* File: core/csb_link_if.sv */
`timescale 1ns/1ps
interface csb_link_if;
  logic ce;
  logic card_rise;
  logic tx_load;
  logic [7:0] tx_data;
  logic tx_done;
  logic rx_en;
  logic rx_start;
  logic rx_done;
  logic rx_busy;
  logic [7:0] rx_data;
  modport div (input ce, output card_rise);
  modport eng (input ce, card_rise, tx_load, tx_data, rx_en,
               output tx_done, rx_start, rx_done, rx_busy, rx_data);
  modport core (output ce, tx_load, tx_data, rx_en,
                input card_rise, tx_done, rx_start, rx_done, rx_busy,
                rx_data);
endinterface

/* File: core/csb_card_div.sv */
`timescale 1ns/1ps
module csb_card_div #(
  parameter int DIV_W = 16
) (
  input wire logic clk_i,               // System clock.
  input wire logic rstn_i,              // Synchronous reset, low.
  input wire logic [DIV_W-1:0] baud_i,  // Divisor value.
  csb_link_if.div lnk,                  // Tick to the engine.
  output logic card_clk_o               // Card clock.
);
  import csb_pkg::*;
  logic [DIV_W-1:0] cnt;

  // ==========================================================
  // Reload divider.
  // The divisor is sampled only at reload, so a mid-run write
  // would bend one half period; software keeps it still.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt <= '0;
      card_clk_o <= 1'b0;
    end else if (lnk.ce) begin
      if (cnt == '0) begin
        cnt <= baud_i;
        card_clk_o <= ~card_clk_o;
      end else begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  assign lnk.card_rise = (cnt == '0) && !card_clk_o;

  // ==========================================================
  // Checks.
  property p_card_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    lnk.ce && cnt != '0 |=> $stable(card_clk_o);
  endproperty
  a_card_hold: assert property (p_card_hold)
    else $error("card clock moved before terminal count");
  property p_card_reload;
    @(posedge clk_i) disable iff (!rstn_i)
    lnk.ce && cnt == '0 |=> cnt == $past(baud_i);
  endproperty
  a_card_reload: assert property (p_card_reload)
    else $error("divider did not reload from divisor");
endmodule

/* File: core/csb_card_eng.sv */
`timescale 1ns/1ps
module csb_card_eng (
  input wire logic clk_i,   // System clock.
  input wire logic rstn_i,  // Synchronous reset, low.
  input wire logic line_i,  // Card data line level.
  csb_link_if.eng lnk,      // Core handshake.
  output logic line_oe_o    // Pull line low.
);
  import csb_pkg::*;
  csb_eng_t state;
  logic [8:0] phase;
  logic [3:0] nbit;
  logic [9:0] sh;
  logic line_q;
  logic bit_end;

  assign bit_end = lnk.ce && lnk.card_rise &&
                   phase == BIT_CARD_CLKS - 9'h001;
  assign lnk.rx_busy = state == ENG_RX;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      line_q <= 1'b1;
    end else if (lnk.ce) begin
      line_q <= line_i;
    end
  end

  // ==========================================================
  // Frame: start bit, eight data bits LSB first, even parity.
  // Ones shift in behind the frame, which gives the guard time.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= ENG_IDLE;
      phase <= '0;
      nbit <= '0;
      sh <= '0;
      line_oe_o <= 1'b0;
      lnk.tx_done <= 1'b0;
      lnk.rx_done <= 1'b0;
      lnk.rx_start <= 1'b0;
      lnk.rx_data <= '0;
    end else if (lnk.ce) begin
      lnk.tx_done <= 1'b0;
      lnk.rx_done <= 1'b0;
      lnk.rx_start <= 1'b0;
      if (lnk.card_rise && state != ENG_IDLE) begin
        phase <= bit_end ? 9'h000 : phase + 9'h001;
      end
      case (state)
        ENG_IDLE: begin
          nbit <= '0;
          if (lnk.tx_load) begin
            sh <= {^lnk.tx_data, lnk.tx_data, 1'b0};
            line_oe_o <= 1'b1;
            phase <= '0;
            state <= ENG_TX;
          end else if (lnk.rx_en && line_q && !line_i) begin
            phase <= HALF_BIT;
            lnk.rx_start <= 1'b1;
            state <= ENG_RX;
          end
        end
        ENG_TX: begin
          if (bit_end) begin
            sh <= {1'b1, sh[9:1]};
            line_oe_o <= !sh[1];
            nbit <= nbit + 4'h1;
            if (nbit == TX_BITS - 4'h1) begin
              lnk.tx_done <= 1'b1;
              state <= ENG_IDLE;
            end
          end
        end
        ENG_RX: begin
          if (bit_end) begin
            sh <= {line_i, sh[9:1]};
            nbit <= nbit + 4'h1;
            if (nbit == RX_BITS - 4'h1) begin
              lnk.rx_data <= sh[9:2];
              lnk.rx_done <= 1'b1;
              state <= ENG_IDLE;
            end
          end
        end
        default: state <= ENG_IDLE;
      endcase
    end
  end

  property p_bit_len;
    @(posedge clk_i) disable iff (!rstn_i)
    state == ENG_TX && $past(state) == ENG_TX && $changed(line_oe_o)
    |-> $past(bit_end);
  endproperty
  a_bit_len: assert property (p_bit_len)
    else $error("transmit bit changed inside its bit period");
endmodule

/* File: core/csb_top.sv */
`timescale 1ns/1ps
module csb_top (
  input wire logic CLK_I,                         // System clock.
  input wire logic RESETN_I,                      // Sync reset, low.
  input wire logic CE_I,                          // Clock enable.
  input wire logic PSEL_I,                        // APB select.
  input wire logic PENABLE_I,                     // APB enable.
  input wire logic PWRITE_I,                      // APB direction.
  input wire logic [csb_pkg::ADDR_W-1:0] PADDR_I, // APB address.
  input wire logic [csb_pkg::DATA_W-1:0] PWDATA_I,// APB write data.
  output logic [csb_pkg::DATA_W-1:0] PRDATA_O,    // APB read data.
  output logic PREADY_O,                          // APB ready.
  output logic PSLVERR_O,                         // APB error.
  output logic IRQ_O,                             // Interrupt, high.
  output logic CARD_CLK_O,                        // Card clock.
  input wire logic CARD_IO_I,                     // Card line in.
  output logic CARD_IO_O,                         // Card line out.
  output logic CARD_IO_OE_O                       // Card line drive.
);
  import csb_pkg::*;

  csb_link_if lnk ();

  logic [REG_W-1:0] baud;
  logic [1:0] ctrl;
  logic [BYTE_W-1:0] tx_buf;
  logic [BYTE_W-1:0] rx_buf;
  logic temp;
  logic tx_shift_empty_flag;
  logic rx_complete_flag;
  logic rx_full;
  logic overrun_flag;
  logic [N_EV-1:0] ist;
  logic [N_EV-1:0] imsk;
  logic [N_EV-1:0] ev;
  logic [REG_W-1:0] rd_val;
  logic mapped;
  logic acc;
  logic wr;
  logic rd;
  logic wr_tx;
  logic wr_rx;
  logic rd_rx;
  logic tx_move;
  logic rx_move;
  logic overrun;

  // ==========================================================
  // Submodules.
  csb_card_div #(
    .DIV_W(REG_W)
  ) u_div (
    .clk_i(CLK_I),
    .rstn_i(RESETN_I),
    .baud_i(baud),
    .lnk(lnk.div),
    .card_clk_o(CARD_CLK_O)
  );

  csb_card_eng u_eng (
    .clk_i(CLK_I),
    .rstn_i(RESETN_I),
    .line_i(CARD_IO_I),
    .lnk(lnk.eng),
    .line_oe_o(CARD_IO_OE_O)
  );

  assign lnk.ce = CE_I;
  assign lnk.rx_en = ctrl[RECEIVE_ENABLE_BIT];
  assign lnk.tx_data = tx_buf;
  assign lnk.tx_load = tx_move;

  // The line is open drain: only a low level is ever driven.
  always_ff @(posedge CLK_I) begin
    CARD_IO_O <= 1'b0;
  end

  // ==========================================================
  // APB slave: one wait state, so every transfer takes one
  // setup and two access cycles.
  assign acc = PSEL_I && PENABLE_I;
  assign wr = CE_I && acc && PREADY_O && PWRITE_I;
  assign rd = CE_I && acc && PREADY_O && !PWRITE_I;
  assign wr_tx = wr && csb_hit(PADDR_I, IDX_TXB);
  assign wr_rx = wr && csb_hit(PADDR_I, IDX_RXB);
  assign rd_rx = rd && csb_hit(PADDR_I, IDX_RXB);

  always_comb begin
    mapped = 1'b1;
    rd_val = '0;
    if (csb_hit(PADDR_I, IDX_CTRL)) begin
      rd_val = {14'h0000, ctrl};
    end else if (csb_hit(PADDR_I, IDX_STAT)) begin
      rd_val = {12'h000, overrun_flag, rx_complete_flag,
                tx_shift_empty_flag, temp};
    end else if (csb_hit(PADDR_I, IDX_IST)) begin
      rd_val = {13'h0000, ist};
    end else if (csb_hit(PADDR_I, IDX_IMSK)) begin
      rd_val = {13'h0000, imsk};
    end else if (csb_hit(PADDR_I, IDX_BAUD)) begin
      rd_val = baud;
    end else if (csb_hit(PADDR_I, IDX_TXB)) begin
      rd_val = {8'h00, tx_buf};
    end else if (csb_hit(PADDR_I, IDX_RXB)) begin
      rd_val = {8'h00, rx_buf};
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= '0;
      PSLVERR_O <= 1'b0;
    end else if (CE_I) begin
      PREADY_O <= acc && !PREADY_O;
      if (acc && !PREADY_O) begin
        PRDATA_O <= {16'h0000, rd_val};
        PSLVERR_O <= !mapped;
      end
    end
  end

  // ==========================================================
  // Configuration registers.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      baud <= BAUD_RST;
      ctrl <= CTRL_RST;
      imsk <= IMSK_RST;
    end else if (wr) begin
      if (csb_hit(PADDR_I, IDX_BAUD)) begin
        baud <= PWDATA_I[REG_W-1:0];
      end
      if (csb_hit(PADDR_I, IDX_CTRL)) begin
        ctrl <= PWDATA_I[1:0];
      end
      if (csb_hit(PADDR_I, IDX_IMSK)) begin
        imsk <= PWDATA_I[N_EV-1:0];
      end
    end
  end

  // ==========================================================
  // Transmit side. Half duplex: a character never starts while
  // the engine is receiving.
  assign tx_move = CE_I && ctrl[TRANSMIT_ENABLE_BIT] && !temp &&
                   (tx_shift_empty_flag || lnk.tx_done) &&
                   !lnk.rx_busy;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      tx_buf <= '0;
    end else if (wr_tx) begin
      tx_buf <= PWDATA_I[BYTE_W-1:0];
    end
  end

  // A write in the same cycle as a move holds new data, so the
  // write keeps the buffer marked full.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      temp <= 1'b1;
    end else if (wr_tx) begin
      temp <= 1'b0;
    end else if (tx_move) begin
      temp <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      tx_shift_empty_flag <= 1'b1;
    end else if (tx_move) begin
      tx_shift_empty_flag <= 1'b0;
    end else if (CE_I && lnk.tx_done) begin
      tx_shift_empty_flag <= 1'b1;
    end
  end

  // ==========================================================
  // Receive side.
  assign rx_move = CE_I && ctrl[RECEIVE_ENABLE_BIT] && rx_full &&
                   !rx_complete_flag;
  assign overrun = CE_I && lnk.rx_start && rx_full &&
                   rx_complete_flag;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rx_full <= 1'b0;
    end else if (CE_I && lnk.rx_done) begin
      rx_full <= 1'b1;
    end else if (rx_move) begin
      rx_full <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rx_buf <= '0;
    end else if (rx_move) begin
      rx_buf <= lnk.rx_data;
    end
  end

  // Set wins over the read that would clear it.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rx_complete_flag <= 1'b0;
    end else if (rx_move) begin
      rx_complete_flag <= 1'b1;
    end else if (rd_rx) begin
      rx_complete_flag <= 1'b0;
    end
  end

  // Overrun clears by writing zero to its status bit.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      overrun_flag <= 1'b0;
    end else if (overrun) begin
      overrun_flag <= 1'b1;
    end else if (wr && csb_hit(PADDR_I, IDX_STAT) &&
                 !PWDATA_I[ST_OVERRUN]) begin
      overrun_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupts: sticky event bits, write one to clear.
  assign ev[EV_TEMP] = tx_move;
  assign ev[EV_RX_COMPLETE] = rx_move;
  assign ev[EV_OVR] = overrun;

  genvar gi;
  generate
    for (gi = 0; gi < N_EV; gi++) begin : g_ist
      always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
          ist[gi] <= 1'b0;
        end else if (ev[gi]) begin
          ist[gi] <= 1'b1;
        end else if (wr && csb_hit(PADDR_I, IDX_IST) &&
                     PWDATA_I[gi]) begin
          ist[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      IRQ_O <= 1'b0;
    end else if (CE_I) begin
      IRQ_O <= |(ist & imsk);
    end
  end

  // ==========================================================
  // Checks.
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  property p_baud_rst;
    $rose(RESETN_I) |-> baud == BAUD_RST;
  endproperty
  a_baud_rst: assert property (p_baud_rst)
    else $error("baud divisor not seven after reset");

  property p_tx_read;
    CE_I && acc && !PREADY_O && !PWRITE_I && csb_hit(PADDR_I, IDX_TXB)
    |=> PRDATA_O[31:8] == 24'h000000 && PRDATA_O[7:0] == $past(tx_buf);
  endproperty
  a_tx_read: assert property (p_tx_read)
    else $error("transmit buffer read data wrong");

  property p_tx_move;
    $fell(tx_shift_empty_flag) |->
      $past(ctrl[TRANSMIT_ENABLE_BIT]) && !$past(temp);
  endproperty
  a_tx_move: assert property (p_tx_move)
    else $error("shifter loaded without enable or data");

  property p_rx_ro;
    wr_rx && !rx_move |=> $stable(rx_buf);
  endproperty
  a_rx_ro: assert property (p_rx_ro)
    else $error("receive buffer changed by a write");

  property p_rx_move;
    $rose(rx_complete_flag) |-> $past(ctrl[RECEIVE_ENABLE_BIT]) &&
      $past(rx_full) ##1 !rx_full;
  endproperty
  a_rx_move: assert property (p_rx_move)
    else $error("receive buffer loaded without conditions");

  property p_temp_flow;
    (wr_tx |=> !temp) and
    (tx_move && !wr_tx |=> temp && !tx_shift_empty_flag);
  endproperty
  a_temp_flow: assert property (p_temp_flow)
    else $error("buffer empty flag did not follow write or move");

  property p_rx_flag_keep;
    rx_complete_flag && !rd_rx |=> rx_complete_flag;
  endproperty
  a_rx_flag_keep: assert property (p_rx_flag_keep)
    else $error("receive complete cleared without buffer read");

  property p_rx_flag_clr;
    rd_rx && !rx_move |=> !rx_complete_flag;
  endproperty
  a_rx_flag_clr: assert property (p_rx_flag_clr)
    else $error("receive complete not cleared by buffer read");

  property p_ovr;
    overrun |=> overrun_flag && ist[EV_OVR];
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun not flagged");

  property p_irq;
    CE_I && |(ist & imsk) |=> IRQ_O;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing for unmasked event");

  c_tx_move: cover property (tx_move);
  c_rx_move: cover property (rx_move);
  c_overrun: cover property (overrun);
endmodule

/* File: tb/csb_card_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Card model on the open-drain line with an external pull-up.
module csb_card_model (
  input wire logic clk_i,        // System clock.
  input wire logic card_clk_i,   // Card clock from the device.
  input wire logic line_i,       // Resolved line level.
  input wire logic go_i,         // Start one frame.
  input wire logic [7:0] byte_i, // Byte to send.
  input wire logic [1:0] gap_i,  // Extra guard bits.
  output logic pull_o,           // Card pulls the line low.
  output logic busy_o,           // Frame in progress.
  output logic [8:0] got_o,      // Parity and byte heard.
  output int got_cnt_o           // Frames heard.
);
  logic [9:0] fr;
  logic [8:0] sh;
  initial begin
    pull_o = 1'b0;
    busy_o = 1'b0;
    got_o = '0;
    got_cnt_o = 0;
  end
  // ==========================================================
  // Sending: start, data LSB first, even parity, released guard.
  always @(posedge clk_i) begin
    if (go_i) begin
      busy_o <= 1'b1;
      fr = {^byte_i, byte_i, 1'b0};
      for (int i = 0; i < 12 + gap_i; i++) begin
        pull_o <= (i < 10) ? ~fr[i] : 1'b0;
        repeat (382) @(posedge card_clk_i);
      end
      busy_o <= 1'b0;
    end
  end
  // ==========================================================
  // Listening: sample mid-bit, counted in card clock rises.
  always begin
    @(negedge line_i iff !pull_o);
    repeat (191) @(posedge card_clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (382) @(posedge card_clk_i);
      sh[i] = line_i;
    end
    got_o <= sh;
    got_cnt_o <= got_cnt_o + 1;
    repeat (382) @(posedge card_clk_i);
  end
endmodule

/* File: tb/test_csb_top.sv */
`timescale 1ns/1ps
module test_csb_top;
  import csb_pkg::*;
  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic e;
  } csb_note_t;
  // Bit time in system cycles while the divisor is zero.
  localparam int BIT_CYC = 2 * 382;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, cclk, io_o, io_oe;
  logic card_pull, card_busy;
  logic card_go = 1'b0;
  logic [7:0] card_byte = '0;
  logic [1:0] card_gap = '0;
  logic [8:0] card_got;
  int card_cnt;
  wire line = ~(io_oe | card_pull);
  int error_cnt = 0;
  int num_checks = 0;
  csb_note_t apb_q[$];
  csb_note_t note;
  logic [8:0] tx_q[$];
  logic [7:0] d, d2, r;
  logic [7:0] rq[3];

  always #4 clk = ~clk;

  csb_top csb_top_i (.CLK_I(clk), .RESETN_I(rstn), .CE_I(1'b1),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .IRQ_O(irq), .CARD_CLK_O(cclk),
    .CARD_IO_I(line), .CARD_IO_O(io_o), .CARD_IO_OE_O(io_oe));

  csb_card_model csb_card_model_i (.clk_i(clk), .card_clk_i(cclk),
    .line_i(line), .go_i(card_go), .byte_i(card_byte),
    .gap_i(card_gap), .pull_o(card_pull), .busy_o(card_busy),
    .got_o(card_got), .got_cnt_o(card_cnt));

  // ==========================================================
  // Checking.
  task automatic cmp(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic bound(input int k, lim);
    if (k >= lim) begin
      error_cnt++;
      $display("unexpected at %0t: wait timed out", $time);
      results();
    end
  endtask

  // Replies are judged in the cycle that PREADY_O stands high.
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1) begin
      note = apb_q.pop_front();
      cmp(prdata & note.m, note.d, "read data");
      cmp({31'h0, pslverr}, {31'h0, note.e}, "slave error");
    end
  end

  always @(card_cnt) begin
    cmp({23'h0, card_got}, {23'h0, tx_q.pop_front()}, "card byte");
  end

  // ==========================================================
  // Drivers.
  task automatic apb(input logic w, input logic [31:0] idx, dt, m,
                     input logic e);
    int k;
    apb_q.push_back('{w ? 32'h0 : dt, w ? 32'h0 : m, e});
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx[29:0], 2'b00};
    pwdata <= dt;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    psel <= 1'b0;
    pen <= 1'b0;
    bound(k, 20);
    @(posedge clk);
  endtask

  task automatic wr(input logic [31:0] idx, dt);
    apb(1'b1, idx, dt, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [31:0] idx, dt, m);
    apb(1'b0, idx, dt, m, 1'b0);
  endtask

  task automatic chk_irq(input logic e);
    @(negedge clk);
    cmp({31'h0, irq}, {31'h0, e}, "interrupt level");
    @(posedge clk);
  endtask

  task automatic idle_wait();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while ((card_busy || tx_q.size() > 0) && k < 40000);
    bound(k, 40000);
  endtask

  task automatic card_send(input logic [7:0] b);
    card_byte <= b;
    card_go <= 1'b1;
    @(posedge clk);
    card_go <= 1'b0;
    idle_wait();
  endtask

  // Counts system cycles between the second and third card clock rise.
  task automatic period(input int exp);
    int k, n, t;
    logic p;
    k = 0;
    n = 0;
    t = 0;
    p = cclk;
    while (n < 3 && k < 1000) begin
      @(posedge clk);
      k++;
      if (!p && cclk) begin
        n++;
        if (n == 2) t = k;
      end
      p = cclk;
    end
    cmp(k - t, exp, "card clock period");
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    void'($urandom(32'h12C3B204));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(IDX_BAUD, 32'h7, 32'hFFFFFFFF);
    rd(IDX_STAT, 32'h3, 32'hF);
    rd(IDX_TXB, 32'h0, 32'hFFFFFF00);
    rd(IDX_RXB, 32'h0, 32'hFFFFFF00);
    period(16);
    $display("test reset values done");
    wr(IDX_BAUD, 32'hFFFFFFFF);
    rd(IDX_BAUD, 32'hFFFF, 32'hFFFFFFFF);
    // The divider already holds the long reload; a reset restarts it.
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(IDX_BAUD, 32'h7, 32'hFFFFFFFF);
    wr(IDX_BAUD, 32'h2);
    period(6);
    wr(IDX_BAUD, 32'h0);
    period(2);
    apb(1'b0, 32'h00238010, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, 32'h00238010, 32'h1, 32'h0, 1'b1);
    $display("test divisor and map done");
    d = 8'($urandom);
    d2 = 8'($urandom);
    wr(IDX_TXB, {24'h0, d});
    rd(IDX_TXB, {24'h0, d}, 32'hFFFFFFFF);
    rd(IDX_STAT, 32'h2, 32'hF);
    cmp({31'h0, io_oe}, 32'h0, "line idle");
    cmp({31'h0, io_o}, 32'h0, "line out level");
    wr(IDX_IMSK, 32'h1);
    tx_q.push_back({^d, d});
    wr(IDX_CTRL, 32'h1);
    rd(IDX_STAT, 32'h1, 32'hF);
    chk_irq(1'b1);
    wr(IDX_TXB, {24'h0, d2});
    tx_q.push_back({^d2, d2});
    rd(IDX_STAT, 32'h0, 32'hF);
    wr(IDX_IST, 32'h7);
    chk_irq(1'b0);
    idle_wait();
    repeat (3 * BIT_CYC) @(posedge clk);
    rd(IDX_STAT, 32'h3, 32'hF);
    rd(IDX_IST, 32'h1, 32'h7);
    wr(IDX_CTRL, 32'h0);
    $display("test transmit done");
    wr(IDX_IST, 32'h7);
    wr(IDX_IMSK, 32'h2);
    wr(IDX_CTRL, 32'h2);
    r = 8'($urandom);
    card_gap <= 2'($urandom);
    card_send(r);
    rd(IDX_STAT, 32'h7, 32'hF);
    rd(IDX_STAT, 32'h7, 32'hF);
    chk_irq(1'b1);
    wr(IDX_RXB, 32'hFFFF);
    rd(IDX_RXB, {24'h0, r}, 32'hFFFFFFFF);
    rd(IDX_STAT, 32'h3, 32'hF);
    $display("test receive done");
    for (int i = 0; i < 3; i++) begin
      rq[i] = 8'($urandom);
      card_send(rq[i]);
    end
    rd(IDX_STAT, 32'hF, 32'hF);
    rd(IDX_IST, 32'h6, 32'h7);
    rd(IDX_RXB, {24'h0, rq[0]}, 32'hFFFFFFFF);
    wr(IDX_STAT, 32'h0);
    rd(IDX_STAT, 32'h7, 32'hF);
    rd(IDX_RXB, {24'h0, rq[2]}, 32'hFFFFFFFF);
    wr(IDX_IMSK, 32'h0);
    chk_irq(1'b0);
    $display("test overrun done");
    results();
  end
endmodule
